// [inc/power_ctrl_pkg.sv]
`default_nettype none
package power_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] AUX_CONFIG_ADDR    = 8'h88;
    localparam logic [7:0] STATUS_ADDR        = 8'h89;
    localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;
    localparam logic [7:0] AUX_CONFIG_RST     = 8'h00;

    // ----------------------------------------------------------------
    // Power control field positions
    // ----------------------------------------------------------------
    localparam int IDLE_BIT     = 0;
    localparam int SLEEP_BIT    = 1;
    localparam int FLAG0_BIT    = 2;
    localparam int FLAG1_BIT    = 3;
    localparam int COLD_BIT     = 4;
    localparam int WAKE_SEL_BIT = 5;
    localparam int FE_VIEW_BIT  = 6;
    localparam int BAUD_DBL_BIT = 7;

    // ----------------------------------------------------------------
    // Auxiliary configuration field positions
    // ----------------------------------------------------------------
    localparam int WDOG_IDLE_BIT = 0;
    localparam int EXT_A_EN_BIT  = 1;
    localparam int EXT_B_EN_BIT  = 2;
    localparam int EXT_A_TRG_BIT = 3;
    localparam int EXT_B_TRG_BIT = 4;
    localparam int CRYSTAL_BIT   = 5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ         = 50;
    localparam int SUT_MIN_US      = 16;
    localparam int SUT_MAX_US      = 16384;
    localparam int SUT_CYCLES_MAX  = SUT_MAX_US * CLK_MHZ;
    localparam int INT_RESET_CYCLES = 2;
    localparam int CNT_W           = 20;

    // Startup time table in microseconds, index {crystal, fuse1, fuse0}.
    localparam int SUT_US_TABLE [8] = '{16, 512, 1024, 4096,
                                        1024, 2048, 4096, 16384};

    typedef enum {
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_WAKE_TIMED,
        ST_WAKE_EXT,
        ST_WAKE_RESET,
        ST_INT_RESET
    } power_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic wdog_clk_en;
        logic osc_en;
        logic bod_en;
        logic flash_en;
        logic int_reset;
    } power_ctl_type;

endpackage : power_ctrl_pkg
`default_nettype wire

// [rtl/power_saving_mode_control.sv]
// Contract
// RULE1: Idle request stops the processor clock; state, RAM and pins hold.
// RULE2: Timers and serial port keep their clocks during idle.
// RULE3: Watchdog runs in idle only when its idle-run enable is set.
// RULE4: Brown-out detector stays enabled throughout idle.
// RULE5: Any enabled interrupt or any reset ends idle.
// RULE6: Hardware clears the idle request on wake from idle.
// RULE7: Power control register at 87H, reset 000X0000, fixed bit layout.
// RULE8: Sleep stops oscillator, disables brown-out detector, powers flash down.
// RULE9: Hardware clears the sleep request on wake from power-down.
// RULE10: Power-down ends only on external reset, power-on, or enabled wake interrupt.
// RULE11: Only the two level-sensitive, enabled external pins wake power-down.
// RULE12: Timed wake: falling edge restarts oscillator, clock gated until timeout.
// RULE13: Timed wake uses fuse startup time; pin need not stay low.
// RULE14: External wake: clock released only at the pin's rising edge.
// RULE15: External source holds the wake pin low until the clock is stable.
// RULE16: Reset pin rising edge in power-down exits and starts the timer.
// RULE17: Reset low before timeout gives two-cycle reset; else held until low.
// RULE18: Cold-start flag set on power-up, software writable, kept on warm reset.
// RULE19: Baud doubler doubles serial baud rate in modes 1, 2 and 3.
// RULE20: Frame-error view select picks mode bit or frame error for bit 7.
// RULE21: Fuse bits and clock source select a 16 to 16384 us startup delay.
`timescale 1ns/10ps
`default_nettype none
module power_saving_mode_control #(
    parameter int SUT_CYCLES_DEFAULT = power_ctrl_pkg::SUT_CYCLES_MAX
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_power_on,
    input  wire logic                        i_reset_pin,
    input  wire logic                        i_ext_irq_pin_a,
    input  wire logic                        i_ext_irq_pin_b,
    input  wire logic [1:0]                  i_sut_fuse,
    input  wire logic                        i_frame_error,
    input  wire logic                        i_serial_mode_bit_hi,
    input  wire logic [1:0]                  i_serial_mode,
    input  wire logic                        i_irq_pending,
    input  wire logic [7:0]                  i_addr,
    input  wire logic [7:0]                  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [7:0]                  o_rdata,
    output power_ctrl_pkg::power_ctl_type    o_ctl,
    output logic                             o_baud_x2,
    output logic                             o_serial_bit7,
    output logic                             o_wake_irq_a,
    output logic                             o_wake_irq_b
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        power_ctrl_pkg::power_state_type    state;
        logic [7:0]                         pctl;
        logic [7:0]                         aux;
        logic [2:0]                         rst_sync;
        logic [2:0]                         a_sync;
        logic [2:0]                         b_sync;
        logic [1:0]                         por_sync;
        logic [power_ctrl_pkg::CNT_W-1:0]   cnt;
        logic                               timeout;
        logic                               wake_a;
        logic                               wake_b;
        logic [7:0]                         rdata;
        power_ctrl_pkg::power_ctl_type      ctl;
        logic                               rst_short;
    } core_state_type;

    core_state_type st_reg;
    core_state_type st_next;

    localparam power_ctrl_pkg::power_state_type
        ST_RUN        = power_ctrl_pkg::ST_RUN,
        ST_IDLE       = power_ctrl_pkg::ST_IDLE,
        ST_SLEEP      = power_ctrl_pkg::ST_SLEEP,
        ST_WAKE_TIMED = power_ctrl_pkg::ST_WAKE_TIMED,
        ST_WAKE_EXT   = power_ctrl_pkg::ST_WAKE_EXT,
        ST_WAKE_RESET = power_ctrl_pkg::ST_WAKE_RESET,
        ST_INT_RESET  = power_ctrl_pkg::ST_INT_RESET;

    // RULE21: fuse delay
    // Startup delay for the current fuse and clock source, in cycles.
    function automatic logic [power_ctrl_pkg::CNT_W-1:0] sut_cycles(
        input logic [2:0] sel
    );
        int us;
        int cyc;
        us  = power_ctrl_pkg::SUT_US_TABLE[sel];
        cyc = us * power_ctrl_pkg::CLK_MHZ;
        if (cyc > SUT_CYCLES_DEFAULT)
        begin
            cyc = SUT_CYCLES_DEFAULT;
        end
        return power_ctrl_pkg::CNT_W'(cyc);
    endfunction : sut_cycles

    logic rst_pin_s;
    logic rst_rise;
    logic a_s;
    logic a_fall;
    logic a_rise;
    logic b_s;
    logic b_fall;
    logic b_rise;
    logic por_s;
    logic wake_a_ok;
    logic wake_b_ok;
    logic [2:0] sut_sel;

    assign rst_pin_s = st_reg.rst_sync[1];
    assign rst_rise  = st_reg.rst_sync[1] & ~st_reg.rst_sync[2];
    assign a_s       = st_reg.a_sync[1];
    assign a_fall    = ~st_reg.a_sync[1] & st_reg.a_sync[2];
    assign a_rise    = st_reg.a_sync[1] & ~st_reg.a_sync[2];
    assign b_s       = st_reg.b_sync[1];
    assign b_fall    = ~st_reg.b_sync[1] & st_reg.b_sync[2];
    assign b_rise    = st_reg.b_sync[1] & ~st_reg.b_sync[2];
    assign por_s     = st_reg.por_sync[1];
    assign sut_sel   = {st_reg.aux[power_ctrl_pkg::CRYSTAL_BIT], i_sut_fuse};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.rst_sync = {st_reg.rst_sync[1:0], i_reset_pin};
        st_next.a_sync   = {st_reg.a_sync[1:0], i_ext_irq_pin_a};
        st_next.b_sync   = {st_reg.b_sync[1:0], i_ext_irq_pin_b};
        st_next.por_sync = {st_reg.por_sync[0], i_power_on};
        st_next.rdata    = 8'h00;

        // RULE11: level wake pins
        wake_a_ok = st_reg.aux[power_ctrl_pkg::EXT_A_EN_BIT]
                  & ~st_reg.aux[power_ctrl_pkg::EXT_A_TRG_BIT];
        wake_b_ok = st_reg.aux[power_ctrl_pkg::EXT_B_EN_BIT]
                  & ~st_reg.aux[power_ctrl_pkg::EXT_B_TRG_BIT];

        // RULE7: register writes
        if (i_wr && i_addr == power_ctrl_pkg::POWER_CONTROL_ADDR)
        begin
            st_next.pctl = i_wdata;
        end
        if (i_wr && i_addr == power_ctrl_pkg::AUX_CONFIG_ADDR)
        begin
            st_next.aux = {2'h0, i_wdata[5:0]};
        end

        // Startup countdown shared by every timed wake.
        if (st_reg.cnt != '0)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        st_next.timeout = (st_reg.cnt == {{(power_ctrl_pkg::CNT_W-1){1'b0}},
                                          1'b1});

        case (st_reg.state)
            ST_RUN:
            begin
                st_next.wake_a = 1'b0;
                st_next.wake_b = 1'b0;
                // RULE8: sleep takes priority
                if (st_reg.pctl[power_ctrl_pkg::SLEEP_BIT])
                begin
                    st_next.state = ST_SLEEP;
                end
                else if (st_reg.pctl[power_ctrl_pkg::IDLE_BIT])
                begin
                    st_next.state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                // RULE5: idle exit
                if (i_irq_pending || rst_pin_s)
                begin
                    // RULE6: clear idle request
                    st_next.pctl[power_ctrl_pkg::IDLE_BIT] = 1'b0;
                    st_next.state = ST_RUN;
                end
            end
            ST_SLEEP:
            begin
                // RULE16: reset pin exit
                if (rst_rise)
                begin
                    st_next.cnt   = sut_cycles(sut_sel);
                    st_next.state = ST_WAKE_RESET;
                end
                // RULE10: interrupt exit
                else if ((a_fall && wake_a_ok) || (b_fall && wake_b_ok))
                begin
                    st_next.wake_a = a_fall & wake_a_ok;
                    st_next.wake_b = b_fall & wake_b_ok;
                    // RULE12: timed or external
                    if (st_reg.pctl[power_ctrl_pkg::WAKE_SEL_BIT])
                    begin
                        // RULE13: fuse time
                        st_next.cnt   = sut_cycles(sut_sel);
                        st_next.state = ST_WAKE_TIMED;
                    end
                    else
                    begin
                        st_next.state = ST_WAKE_EXT;
                    end
                end
            end
            ST_WAKE_TIMED:
            begin
                if (st_reg.timeout)
                begin
                    // RULE9: clear sleep request
                    st_next.pctl[power_ctrl_pkg::SLEEP_BIT] = 1'b0;
                    st_next.state = ST_RUN;
                end
            end
            ST_WAKE_EXT:
            begin
                // RULE14: release on rising edge
                if ((st_reg.wake_a && a_rise) || (st_reg.wake_b && b_rise))
                begin
                    st_next.pctl[power_ctrl_pkg::SLEEP_BIT] = 1'b0;
                    st_next.state = ST_RUN;
                end
            end
            ST_WAKE_RESET:
            begin
                // RULE17: short or held reset
                if (!rst_pin_s && st_reg.cnt != '0 && !st_reg.rst_short)
                begin
                    st_next.state = ST_INT_RESET;
                end
                else if (!rst_pin_s && st_reg.cnt == '0)
                begin
                    st_next.rst_short = 1'b0;
                    st_next.pctl  = st_reg.pctl &
                                    (8'h01 << power_ctrl_pkg::COLD_BIT);
                    st_next.state = ST_RUN;
                end
            end
            ST_INT_RESET:
            begin
                if (st_reg.cnt == '0)
                begin
                    st_next.cnt = power_ctrl_pkg::CNT_W'(
                                  power_ctrl_pkg::INT_RESET_CYCLES);
                    st_next.pctl  = st_reg.pctl &
                                    (8'h01 << power_ctrl_pkg::COLD_BIT);
                    st_next.rst_short = 1'b1;
                    st_next.state = ST_WAKE_RESET;
                end
            end
            default:
            begin
                st_next.state = ST_RUN;
            end
        endcase

        // Reset pin held outside power-down is a warm reset of the fields.
        if (rst_pin_s && st_reg.state != ST_SLEEP
            && st_reg.state != ST_WAKE_RESET && st_reg.state != ST_INT_RESET)
        begin
            // RULE18: warm reset keeps flag
            st_next.pctl  = st_reg.pctl & (8'h01 << power_ctrl_pkg::COLD_BIT);
            st_next.state = ST_RUN;
        end
        // RULE18: cold start sets flag
        if (por_s)
        begin
            st_next.pctl  = 8'h01 << power_ctrl_pkg::COLD_BIT;
            st_next.aux   = power_ctrl_pkg::AUX_CONFIG_RST;
            st_next.state = ST_RUN;
            st_next.cnt   = '0;
        end

        // Register reads.
        if (i_rd)
        begin
            case (i_addr)
                power_ctrl_pkg::POWER_CONTROL_ADDR: st_next.rdata = st_reg.pctl;
                power_ctrl_pkg::AUX_CONFIG_ADDR:    st_next.rdata = st_reg.aux;
                power_ctrl_pkg::STATUS_ADDR:
                    st_next.rdata = {5'h00, 3'(st_reg.state)};
                default:                            st_next.rdata = 8'h00;
            endcase
        end

        // RULE1: processor clock gate
        st_next.ctl.cpu_clk_en = (st_next.state == ST_RUN);
        // RULE2: peripherals run in idle
        st_next.ctl.periph_clk_en = (st_next.state == ST_RUN)
                                  || (st_next.state == ST_IDLE);
        // RULE3: watchdog idle run
        st_next.ctl.wdog_clk_en = (st_next.state == ST_RUN)
            || ((st_next.state == ST_IDLE)
                && st_next.aux[power_ctrl_pkg::WDOG_IDLE_BIT]);
        // RULE8: oscillator and flash off
        st_next.ctl.osc_en   = (st_next.state != ST_SLEEP);
        st_next.ctl.flash_en = (st_next.state != ST_SLEEP);
        // RULE4: brown-out on in idle
        st_next.ctl.bod_en   = (st_next.state != ST_SLEEP);
        st_next.ctl.int_reset = (st_next.state == ST_INT_RESET)
                              || (st_next.state == ST_WAKE_RESET);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            st_reg       <= '0;
            st_reg.state <= ST_RUN;
            st_reg.pctl  <= power_ctrl_pkg::POWER_CONTROL_RST;
            st_reg.aux   <= power_ctrl_pkg::AUX_CONFIG_RST;
            st_reg.ctl   <= 7'h7E;
            st_reg.a_sync <= '1;
            st_reg.b_sync <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata      = st_reg.rdata;
    assign o_ctl        = st_reg.ctl;
    assign o_wake_irq_a = st_reg.wake_a;
    assign o_wake_irq_b = st_reg.wake_b;

    // RULE19: baud doubler in modes 1-3
    assign o_baud_x2 = st_reg.pctl[power_ctrl_pkg::BAUD_DBL_BIT]
                     & (i_serial_mode != 2'h0);
    // RULE20: frame error view select
    assign o_serial_bit7 = st_reg.pctl[power_ctrl_pkg::FE_VIEW_BIT]
                         ? i_frame_error : i_serial_mode_bit_hi;

endmodule : power_saving_mode_control
`default_nettype wire

// [verification/power_saving_mode_control_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module power_saving_mode_control_properties #(
    parameter int SUT_CYCLES_DEFAULT = 20
) (
    input wire logic                          i_core_clk,
    input wire logic                          i_nrst,
    input wire logic                          i_power_on,
    input wire logic                          i_reset_pin,
    input wire logic                          i_ext_irq_pin_a,
    input wire logic                          i_ext_irq_pin_b,
    input wire logic [1:0]                    i_sut_fuse,
    input wire logic                          i_frame_error,
    input wire logic                          i_serial_mode_bit_hi,
    input wire logic [1:0]                    i_serial_mode,
    input wire logic                          i_irq_pending,
    input wire logic [7:0]                    i_addr,
    input wire logic [7:0]                    i_wdata,
    input wire logic                          i_wr,
    input wire logic                          i_rd,
    input wire logic [7:0]                    o_rdata,
    input wire power_ctrl_pkg::power_ctl_type o_ctl,
    input wire logic                          o_baud_x2,
    input wire logic                          o_serial_bit7,
    input wire logic                          o_wake_irq_a,
    input wire logic                          o_wake_irq_b
);
    // ------------------------------------------------------------
    // Wake cause history
    // ------------------------------------------------------------
    // Pins pass a synchroniser first, so causes are kept a few cycles.
    logic [5:0] cause_reg;
    logic [5:0] pin_a_reg;
    always_ff @(posedge i_core_clk)
    begin
        cause_reg <= {cause_reg[4:0], !i_ext_irq_pin_a || !i_ext_irq_pin_b
                      || i_reset_pin || i_power_on};
        pin_a_reg <= {pin_a_reg[4:0], !i_ext_irq_pin_a};
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_SLEEP_OFF: assert property (
        !o_ctl.osc_en |-> !o_ctl.bod_en && !o_ctl.flash_en && !o_ctl.cpu_clk_en)
        else $error("core or detector powered with oscillator stopped");
    AST_RDATA_STROBE: assert property (
        o_rdata != 8'h00 |-> $past(i_rd))
        else $error("read data without a read strobe");
    AST_UNMAPPED: assert property (
        i_rd && i_addr > 8'h89 |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");
    AST_OSC_CAUSE: assert property (
        $rose(o_ctl.osc_en) |-> |cause_reg)
        else $error("power-down left without a wake cause");
    AST_GATE_AFTER_OSC: assert property (
        $rose(o_ctl.osc_en) |-> !o_ctl.cpu_clk_en [*8])
        else $error("core clock released too soon after restart");
    AST_CPU_PINS_HIGH: assert property (
        $rose(o_ctl.cpu_clk_en) |-> i_ext_irq_pin_a && i_ext_irq_pin_b)
        else $error("core clock released while a wake pin is low");
    AST_BAUD_MODE0: assert property (
        o_baud_x2 |-> i_serial_mode != 2'h0)
        else $error("baud doubled in serial mode 0");
    AST_FE_VIEW: assert property (
        i_frame_error == i_serial_mode_bit_hi |-> o_serial_bit7 == i_frame_error)
        else $error("serial bit 7 matches neither source");
    AST_WAKE_FLAG: assert property (
        $rose(o_wake_irq_a) |-> |pin_a_reg)
        else $error("wake source flagged without its pin");
    COV_IDLE: cover property (!o_ctl.cpu_clk_en && o_ctl.osc_en);
    COV_SLEEP: cover property ($fell(o_ctl.osc_en));
    COV_INT_RESET: cover property ($rose(o_ctl.int_reset));
    COV_WAKE_A: cover property ($rose(o_wake_irq_a));
endmodule : power_saving_mode_control_properties

bind power_saving_mode_control power_saving_mode_control_properties #(
    .SUT_CYCLES_DEFAULT(SUT_CYCLES_DEFAULT)
) i_power_saving_mode_control_properties (.*);
`default_nettype wire

// [verification/tb_power_saving_mode_control.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_power_saving_mode_control;
    localparam int SUT = 20;
    logic       i_core_clk, i_nrst, i_power_on, i_frame_error, i_wr, i_rd;
    logic       i_serial_mode_bit_hi, i_irq_pending, rst_pin, pin_a, pin_b;
    logic [1:0] i_serial_mode;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic       o_baud_x2, o_serial_bit7, o_wake_irq_a, o_wake_irq_b;
    power_ctrl_pkg::power_ctl_type o_ctl;
    int         mismatches, check_count, cycles, irst, run_cycles;

    power_saving_mode_control #(.SUT_CYCLES_DEFAULT(SUT)) i_power_saving_mode_control (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_power_on(i_power_on),
        .i_reset_pin(rst_pin), .i_ext_irq_pin_a(pin_a), .i_ext_irq_pin_b(pin_b),
        .i_sut_fuse(2'b00), .i_frame_error(i_frame_error),
        .i_serial_mode_bit_hi(i_serial_mode_bit_hi), .i_serial_mode(i_serial_mode),
        .i_irq_pending(i_irq_pending), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ctl(o_ctl),
        .o_baud_x2(o_baud_x2), .o_serial_bit7(o_serial_bit7),
        .o_wake_irq_a(o_wake_irq_a), .o_wake_irq_b(o_wake_irq_b));
    wake_source i_wake_source (.i_core_clk(i_core_clk), .o_reset_pin(rst_pin),
        .o_pin_a(pin_a), .o_pin_b(pin_b));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    // Bounded wait for the core clock.
    task automatic wait_cpu(input int limit);
        cycles = 0;
        irst = 0;
        while (o_ctl.cpu_clk_en !== 1'b1 && cycles < limit)
        begin
            @(posedge i_core_clk);
            #1 cycles++;
            irst += int'(o_ctl.int_reset === 1'b1);
        end
    endtask : wait_cpu
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_map;
        #1 check({1'b0, o_ctl}, 8'h7E);
        rd(8'h87, d); check(d, 8'h00);
        rd(8'h88, d); check(d, 8'h00);
        wr(8'h90, 8'h33); rd(8'h90, d); check(d, 8'h00);
        rd(8'h87, d); check(d, 8'h00);
    endtask : t_map
    task automatic t_cold;
        @(posedge i_core_clk) i_power_on <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_power_on <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        rd(8'h87, d); check(d, 8'h10);
        wr(8'h87, 8'h0C); rd(8'h87, d); check(d, 8'h0C);
        wr(8'h87, 8'h1C);
        i_wake_source.drive(2, 4);
        repeat (3) @(posedge i_core_clk);
        rd(8'h87, d); check(d, 8'h10);
        wr(8'h87, 8'h00);
    endtask : t_cold
    task automatic t_idle(input logic w);
        wr(8'h88, {7'h00, w});
        wr(8'h87, 8'h01);
        repeat (3) @(posedge i_core_clk);
        #1 check({1'b0, o_ctl} & 8'h7D, {3'b001, w, 4'hC});
        rd(8'h89, d); check(d, 8'h01);
        @(posedge i_core_clk) i_irq_pending <= 1'b1;
        #1 wait_cpu(10);
        i_irq_pending <= 1'b0;
        check(o_ctl.cpu_clk_en, 1'b1);
        rd(8'h87, d); check(d, 8'h00);
    endtask : t_idle
    task automatic t_sleep_timed;
        wr(8'h88, 8'h02);
        wr(8'h87, 8'h22);
        repeat (3) @(posedge i_core_clk);
        #1 check({1'b0, o_ctl} & 8'h4E, 8'h00);
        i_irq_pending <= 1'b1;
        i_wake_source.drive(1, 10);
        i_irq_pending <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        #1 check(o_ctl.osc_en, 1'b0);
        i_wake_source.drive(0, 2);
        #1 wait_cpu(200);
        check(cycles >= SUT - 4 && cycles <= SUT + 8, 1'b1);
        rd(8'h87, d); check(d, 8'h20);
    endtask : t_sleep_timed
    task automatic t_sleep_ext;
        wr(8'h87, 8'h02);
        fork
            i_wake_source.drive(0, 40);
            begin
                repeat (30) @(posedge i_core_clk);
                #1 check({o_wake_irq_b, o_wake_irq_a, o_ctl.osc_en,
                          o_ctl.cpu_clk_en}, 8'h6);
            end
        join
        #1 wait_cpu(10);
        check(o_ctl.cpu_clk_en, 1'b1);
        rd(8'h87, d); check(d, 8'h00);
    endtask : t_sleep_ext
    task automatic t_sleep_rst;
        wr(8'h87, 8'h02);
        i_wake_source.drive(2, 4);
        #1 wait_cpu(200);
        check({o_ctl.cpu_clk_en, o_ctl.int_reset}, 8'h2);
        check(irst > 0, 1'b1);
        wr(8'h87, 8'h02);
        fork
            i_wake_source.drive(2, 60);
            begin
                repeat (50) @(posedge i_core_clk);
                #1 check({o_ctl.cpu_clk_en, o_ctl.int_reset}, 8'h1);
            end
        join
        #1 wait_cpu(20);
        check(o_ctl.cpu_clk_en, 1'b1);
    endtask : t_sleep_rst
    task automatic t_serial;
        i_frame_error <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            i_serial_mode <= 2'(m);
            wr(8'h87, 8'h80);
            #1 check(o_baud_x2, m != 0);
        end
        wr(8'h87, 8'h40);
        #1 check(o_serial_bit7, 1'b1);
        wr(8'h87, 8'h00);
        #1 check(o_serial_bit7, 1'b0);
    endtask : t_serial

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        run_cycles++;
        if (run_cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        {i_nrst, i_power_on, i_frame_error, i_wr, i_rd} = 5'h00;
        {i_serial_mode_bit_hi, i_irq_pending, i_serial_mode} = 4'h0;
        {i_addr, i_wdata} = 16'h0000;
        {mismatches, check_count, run_cycles} = 0;
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_map();
        t_cold();
        t_idle(1'b0);
        t_idle(1'b1);
        t_sleep_timed();
        t_sleep_ext();
        t_sleep_rst();
        t_serial();
        stop_test();
    end
endmodule : tb_power_saving_mode_control
`default_nettype wire

// [verification/wake_source.sv]
`timescale 1ns/10ps
`default_nettype none
module wake_source (
    input  wire logic i_core_clk,
    output logic      o_reset_pin,
    output logic      o_pin_a,
    output logic      o_pin_b
);
    // Released lines fall to their pull: wake pins up, reset pin down.
    initial
    begin
        o_reset_pin = 1'b0;
        o_pin_a = 1'b1;
        o_pin_b = 1'b1;
    end
    task automatic drive(input int sel, input int cycles);
        @(posedge i_core_clk);
        if (sel == 0)
            o_pin_a <= 1'b0;
        else if (sel == 1)
            o_pin_b <= 1'b0;
        else
            o_reset_pin <= 1'b1;
        repeat (cycles) @(posedge i_core_clk);
        o_pin_a <= 1'b1;
        o_pin_b <= 1'b1;
        o_reset_pin <= 1'b0;
    endtask : drive
endmodule : wake_source
`default_nettype wire
